// ==== rcsf_consts.vh ====
`ifndef RCSF_CONSTS_VH
`define RCSF_CONSTS_VH

`define RCSF_START_BYTE      8'h7E
`define RCSF_TYPE_REMOTE_CMD 8'h17
`define RCSF_TYPE_STATUS     8'h8A
`define RCSF_TYPE_TX_RESULT  8'h8B
`define RCSF_TYPE_TX_REQ_A   8'h10
`define RCSF_TYPE_TX_REQ_B   8'h11
`define RCSF_CSUM_BASE       8'hFF
`define RCSF_RESERVED_HI     8'hFF
`define RCSF_RESERVED_LO     8'hFE
`define RCSF_OPT_APPLY       8'h02
`define RCSF_EVT_HW_RESET    8'h00
`define RCSF_EVT_WDT_RESET   8'h01
`define RCSF_EVT_NET_WAKE    8'h0B
`define RCSF_EVT_NET_SLEEP   8'h0C
`define RCSF_DISC_NONE       8'h00
`define RCSF_DISC_ROUTE      8'h02
`define RCSF_LEN_STATUS      8'h02
`define RCSF_LEN_TX_RESULT   8'h07
`define RCSF_OFS_FRAME_ID    8'h04
`define RCSF_OFS_ADDR_FIRST  8'h05
`define RCSF_OFS_ADDR_LAST   8'h0C
`define RCSF_OFS_RSVD_HI     8'h0D
`define RCSF_OFS_RSVD_LO     8'h0E
`define RCSF_OFS_OPTIONS     8'h0F
`define RCSF_OFS_CMD_HI      8'h10
`define RCSF_OFS_CMD_LO      8'h11
`define RCSF_OFS_PARAM       8'h12
`define RCSF_MAX_PARAM       16

`endif

// ==== rcsf_fifo.v ====
`timescale 1ns/1ps
module rcsf_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             nrst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wp_q;
    reg [AW-1:0]    rp_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem[rp_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp_q  <= {AW{1'b0}};
            rp_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // rcsf_fifo

// ==== rcsf_parser.v ====
`timescale 1ns/1ps
`include "rcsf_consts.vh"
module rcsf_parser #(
    parameter MAX_PARAM = `RCSF_MAX_PARAM
) (
    input  wire        clk,
    input  wire        nrst,
    input  wire [7:0]  rx_data,
    input  wire        rx_valid,
    output wire        rx_ready,
    output reg         cmd_valid,
    output reg  [7:0]  cmd_frame_id,
    output reg  [63:0] cmd_addr,
    output reg         cmd_broadcast,
    output reg         cmd_apply,
    output reg  [15:0] cmd_name,
    output reg  [7:0]  cmd_param_len,
    output reg  [7:0]  cmd_param_byte0,
    output reg         cmd_query,
    output reg         txreq_valid,
    output reg  [7:0]  txreq_frame_id,
    output reg         bad_frame
);
    localparam S_IDLE = 3'd0;
    localparam S_LENH = 3'd1;
    localparam S_LENL = 3'd2;
    localparam S_BODY = 3'd3;
    localparam S_CSUM = 3'd4;

    reg [2:0]  st_q;
    reg [15:0] len_q;
    reg [15:0] idx_q;
    reg [7:0]  sum_q;
    reg [7:0]  type_q;
    reg [7:0]  fid_q;
    reg [63:0] addr_q;
    reg [7:0]  opt_q;
    reg [15:0] name_q;
    reg [7:0]  p0_q;
    wire [7:0] ofs;

    assign rx_ready = 1'b1;
    assign ofs      = (idx_q[15:8] != 8'h00) ? 8'hFF : idx_q[7:0] + 8'h03;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q            <= S_IDLE;
            len_q           <= 16'h0000;
            idx_q           <= 16'h0000;
            sum_q           <= 8'h00;
            type_q          <= 8'h00;
            fid_q           <= 8'h00;
            addr_q          <= 64'h0;
            opt_q           <= 8'h00;
            name_q          <= 16'h0000;
            p0_q            <= 8'h00;
            cmd_valid       <= 1'b0;
            cmd_frame_id    <= 8'h00;
            cmd_addr        <= 64'h0;
            cmd_broadcast   <= 1'b0;
            cmd_apply       <= 1'b0;
            cmd_name        <= 16'h0000;
            cmd_param_len   <= 8'h00;
            cmd_param_byte0 <= 8'h00;
            cmd_query       <= 1'b0;
            txreq_valid     <= 1'b0;
            txreq_frame_id  <= 8'h00;
            bad_frame       <= 1'b0;
        end else begin
            cmd_valid   <= 1'b0;
            txreq_valid <= 1'b0;
            bad_frame   <= 1'b0;
            if (rx_valid) begin
                case (st_q)
                    S_IDLE: begin
                        if (rx_data == `RCSF_START_BYTE) begin
                            st_q <= S_LENH;
                        end
                    end
                    S_LENH: begin
                        len_q[15:8] <= rx_data;
                        st_q        <= S_LENL;
                    end
                    S_LENL: begin
                        len_q[7:0] <= rx_data;
                        idx_q      <= 16'h0000;
                        sum_q      <= 8'h00;
                        if ({len_q[15:8], rx_data} == 16'h0000) begin
                            st_q <= S_IDLE;
                        end else begin
                            st_q <= S_BODY;
                        end
                    end
                    S_BODY: begin
                        sum_q <= sum_q + rx_data;
                        idx_q <= idx_q + 16'h0001;
                        if (idx_q == 16'h0000) begin
                            type_q <= rx_data;
                        end
                        if (ofs == `RCSF_OFS_FRAME_ID) begin
                            fid_q <= rx_data;
                        end
                        if (ofs >= `RCSF_OFS_ADDR_FIRST &&
                            ofs <= `RCSF_OFS_ADDR_LAST) begin
                            addr_q <= {addr_q[55:0], rx_data};
                        end
                        if (ofs == `RCSF_OFS_OPTIONS) begin
                            opt_q <= rx_data;
                        end
                        if (ofs == `RCSF_OFS_CMD_HI) begin
                            name_q[15:8] <= rx_data;
                        end
                        if (ofs == `RCSF_OFS_CMD_LO) begin
                            name_q[7:0] <= rx_data;
                        end
                        if (ofs == `RCSF_OFS_PARAM) begin
                            p0_q <= rx_data;
                        end
                        if (idx_q + 16'h0001 == len_q) begin
                            st_q <= S_CSUM;
                        end
                    end
                    S_CSUM: begin
                        st_q <= S_IDLE;
                        // Bad checksum drops the frame and pulses bad_frame
                        if (rx_data == `RCSF_CSUM_BASE - sum_q) begin
                            if (type_q == `RCSF_TYPE_REMOTE_CMD &&
                                len_q >= 16'h000F) begin
                                cmd_valid     <= 1'b1;
                                cmd_frame_id  <= fid_q;
                                cmd_addr      <= addr_q;
                                cmd_broadcast <= (addr_q[15:0] == 16'hFFFF);
                                cmd_apply     <= opt_q[1];
                                cmd_name      <= name_q;
                                cmd_param_len <= (len_q > MAX_PARAM + 8'h0F) ?
                                    MAX_PARAM[7:0] : len_q[7:0] - 8'h0F;
                                cmd_param_byte0 <= p0_q;
                                cmd_query     <= (len_q == 16'h000F);
                            end
                            if ((type_q == `RCSF_TYPE_TX_REQ_A ||
                                 type_q == `RCSF_TYPE_TX_REQ_B) &&
                                len_q >= 16'h0002) begin
                                txreq_valid    <= 1'b1;
                                txreq_frame_id <= fid_q;
                            end
                        end else begin
                            bad_frame <= 1'b1;
                        end
                    end
                    default: begin
                        st_q <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // rcsf_parser

// ==== rcsf_top.v ====
`timescale 1ns/1ps
`include "rcsf_consts.vh"
module rcsf_top #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW    = 4,
    parameter MAX_PARAM  = `RCSF_MAX_PARAM
) (
    input  wire        clk,
    input  wire        nrst,
    input  wire [7:0]  rx_data,
    input  wire        rx_valid,
    output wire        rx_ready,
    output wire [7:0]  tx_data,
    output wire        tx_valid,
    input  wire        tx_ready,
    input  wire        evt_wdt_reset,
    input  wire        evt_net_wake,
    input  wire        evt_net_sleep,
    input  wire        tx_done,
    input  wire [7:0]  tx_done_retries,
    input  wire [7:0]  tx_done_delivery,
    input  wire        tx_done_discovery,
    output wire        cmd_valid,
    output wire [7:0]  cmd_frame_id,
    output wire [63:0] cmd_addr,
    output wire        cmd_broadcast,
    output wire        cmd_apply,
    output wire [15:0] cmd_name,
    output wire [7:0]  cmd_param_len,
    output wire [7:0]  cmd_param_byte0,
    output wire        cmd_query,
    output wire        cmd_respond,
    output wire        txreq_valid,
    output wire [7:0]  txreq_frame_id,
    output wire        bad_frame,
    output wire        tx_busy
);
    localparam G_IDLE = 2'd0;
    localparam G_SEND = 2'd1;

    reg [1:0]  gst_q;
    reg [3:0]  idx_q;
    reg [3:0]  last_q;
    reg [7:0]  sum_q;
    reg [7:0]  kind_q;
    reg [7:0]  b4_q;
    reg [7:0]  b7_q;
    reg [7:0]  b8_q;
    reg [7:0]  b9_q;
    reg        pend_boot_q;
    reg        pend_wdt_q;
    reg        pend_wake_q;
    reg        pend_sleep_q;
    reg        pend_res_q;
    reg [7:0]  res_id_q;
    reg [7:0]  res_try_q;
    reg [7:0]  res_del_q;
    reg        res_disc_q;
    reg [7:0]  cur_id_q;
    reg [7:0]  gen_byte;
    wire       f_ready;
    wire       f_push;
    wire       status_pend;

    rcsf_parser #(
        .MAX_PARAM (MAX_PARAM)
    ) u_parser (
        .clk             (clk),
        .nrst            (nrst),
        .rx_data         (rx_data),
        .rx_valid        (rx_valid),
        .rx_ready        (rx_ready),
        .cmd_valid       (cmd_valid),
        .cmd_frame_id    (cmd_frame_id),
        .cmd_addr        (cmd_addr),
        .cmd_broadcast   (cmd_broadcast),
        .cmd_apply       (cmd_apply),
        .cmd_name        (cmd_name),
        .cmd_param_len   (cmd_param_len),
        .cmd_param_byte0 (cmd_param_byte0),
        .cmd_query       (cmd_query),
        .txreq_valid     (txreq_valid),
        .txreq_frame_id  (txreq_frame_id),
        .bad_frame       (bad_frame)
    );

    // Remote side must not answer requests with zero identifier
    assign cmd_respond = (cmd_frame_id != 8'h00);

    rcsf_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_data   (gen_byte),
        .in_valid  (f_push),
        .in_ready  (f_ready),
        .out_data  (tx_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );

    assign f_push      = (gst_q == G_SEND);
    assign tx_busy     = (gst_q == G_SEND);
    assign status_pend = pend_boot_q | pend_wdt_q | pend_wake_q |
                         pend_sleep_q;

    // Frame byte by position; checksum computed on the fly
    always @* begin
        gen_byte = 8'h00;
        case (idx_q)
            4'd0: gen_byte = `RCSF_START_BYTE;
            4'd1: gen_byte = 8'h00;
            4'd2: gen_byte = (kind_q == `RCSF_TYPE_STATUS) ?
                             `RCSF_LEN_STATUS : `RCSF_LEN_TX_RESULT;
            4'd3: gen_byte = kind_q;
            4'd4: gen_byte = b4_q;
            4'd5: gen_byte = `RCSF_RESERVED_HI;
            4'd6: gen_byte = `RCSF_RESERVED_LO;
            4'd7: gen_byte = b7_q;
            4'd8: gen_byte = b8_q;
            4'd9: gen_byte = b9_q;
            default: gen_byte = 8'h00;
        endcase
        if (idx_q == last_q) begin
            gen_byte = `RCSF_CSUM_BASE - sum_q;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gst_q        <= G_IDLE;
            idx_q        <= 4'd0;
            last_q       <= 4'd0;
            sum_q        <= 8'h00;
            kind_q       <= 8'h00;
            b4_q         <= 8'h00;
            b7_q         <= 8'h00;
            b8_q         <= 8'h00;
            b9_q         <= 8'h00;
            pend_boot_q  <= 1'b1;
            pend_wdt_q   <= 1'b0;
            pend_wake_q  <= 1'b0;
            pend_sleep_q <= 1'b0;
            pend_res_q   <= 1'b0;
            res_id_q     <= 8'h00;
            res_try_q    <= 8'h00;
            res_del_q    <= 8'h00;
            res_disc_q   <= 1'b0;
            cur_id_q     <= 8'h00;
        end else begin
            if (txreq_valid) begin
                cur_id_q <= txreq_frame_id;
            end
            // Single result slot; a newer completion overwrites it
            if (tx_done && cur_id_q != 8'h00) begin
                pend_res_q <= 1'b1;
                res_id_q   <= cur_id_q;
                res_try_q  <= tx_done_retries;
                res_del_q  <= tx_done_delivery;
                res_disc_q <= tx_done_discovery;
            end
            case (gst_q)
                G_IDLE: begin
                    idx_q <= 4'd0;
                    sum_q <= 8'h00;
                    if (status_pend) begin
                        gst_q  <= G_SEND;
                        kind_q <= `RCSF_TYPE_STATUS;
                        last_q <= 4'd5;
                        if (pend_boot_q) begin
                            b4_q        <= `RCSF_EVT_HW_RESET;
                            pend_boot_q <= 1'b0;
                        end else if (pend_wdt_q) begin
                            b4_q       <= `RCSF_EVT_WDT_RESET;
                            pend_wdt_q <= 1'b0;
                        end else if (pend_wake_q) begin
                            b4_q        <= `RCSF_EVT_NET_WAKE;
                            pend_wake_q <= 1'b0;
                        end else begin
                            b4_q         <= `RCSF_EVT_NET_SLEEP;
                            pend_sleep_q <= 1'b0;
                        end
                    end else if (pend_res_q && !tx_done) begin
                        gst_q      <= G_SEND;
                        kind_q     <= `RCSF_TYPE_TX_RESULT;
                        last_q     <= 4'd10;
                        b4_q       <= res_id_q;
                        b7_q       <= res_try_q;
                        b8_q       <= res_del_q;
                        b9_q       <= res_disc_q ? `RCSF_DISC_ROUTE :
                                      `RCSF_DISC_NONE;
                        pend_res_q <= 1'b0;
                    end
                end
                G_SEND: begin
                    // Stalls while the FIFO is full
                    if (f_ready) begin
                        if (idx_q >= 4'd3) begin
                            sum_q <= sum_q + gen_byte;
                        end
                        if (idx_q == last_q) begin
                            gst_q <= G_IDLE;
                        end else begin
                            idx_q <= idx_q + 4'd1;
                        end
                    end
                end
                default: begin
                    gst_q <= G_IDLE;
                end
            endcase
            // Set wins over clear when an event hits the same cycle
            if (evt_wdt_reset) begin
                pend_wdt_q <= 1'b1;
            end
            if (evt_net_wake) begin
                pend_wake_q <= 1'b1;
            end
            if (evt_net_sleep) begin
                pend_sleep_q <= 1'b1;
            end
        end
    end
endmodule // rcsf_top

// ==== rcsf_monitor.sv ====
`timescale 1ns/1ps
module rcsf_monitor (
    input wire        clk,
    input wire        nrst,
    input wire [7:0]  tx_data,
    input wire        tx_valid,
    input wire        tx_ready,
    input wire        cmd_valid,
    input wire [7:0]  cmd_frame_id,
    input wire [63:0] cmd_addr,
    input wire        cmd_broadcast,
    input wire [7:0]  cmd_param_len,
    input wire        cmd_query,
    input wire        cmd_respond,
    input wire        txreq_valid,
    input wire        bad_frame
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    reg  [4:0] pos_q;
    reg  [7:0] len_q;
    reg  [7:0] sum_q;
    reg  [7:0] typ_q;
    wire       take = tx_valid && tx_ready;
    wire       last = (pos_q == len_q[4:0] + 5'h03);

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pos_q <= 5'h00;
            len_q <= 8'h00;
            sum_q <= 8'h00;
            typ_q <= 8'h00;
        end else if (take) begin
            pos_q <= last ? 5'h00 : pos_q + 5'h01;
            sum_q <= (pos_q < 5'h03) ? 8'h00 : sum_q + tx_data;
            if (pos_q == 5'h02) len_q <= tx_data;
            if (pos_q == 5'h03) typ_q <= tx_data;
        end
    end

    a_start_byte: assert property (
        take && pos_q == 5'h00 |-> tx_data == 8'h7E)
        else $error("no start byte");
    a_len_msb: assert property (
        take && pos_q == 5'h01 |-> tx_data == 8'h00)
        else $error("length MSB not zero");
    a_len_type: assert property (
        take && pos_q == 5'h03 |-> (len_q == 8'h02 && tx_data == 8'h8A)
        || (len_q == 8'h07 && tx_data == 8'h8B))
        else $error("type and length disagree");
    a_csum_ok: assert property (
        take && pos_q > 5'h02 && last |-> 8'(sum_q + tx_data) == 8'hFF)
        else $error("checksum byte wrong");
    a_rsvd_field: assert property (
        take && typ_q == 8'h8B && (pos_q == 5'h05 || pos_q == 5'h06)
        |-> tx_data == (pos_q == 5'h05 ? 8'hFF : 8'hFE))
        else $error("reserved bytes wrong");
    a_disc_code: assert property (
        take && typ_q == 8'h8B && pos_q == 5'h09
        |-> tx_data == 8'h00 || tx_data == 8'h02)
        else $error("discovery code out of range");
    a_respond_flag: assert property (
        cmd_respond == (cmd_frame_id != 8'h00))
        else $error("respond flag wrong");
    a_query_flag: assert property (
        cmd_valid |-> cmd_query == (cmd_param_len == 8'h00))
        else $error("query flag wrong");
    a_bcast_flag: assert property (
        cmd_valid |-> cmd_broadcast == (cmd_addr[15:0] == 16'hFFFF))
        else $error("broadcast flag wrong");
    a_bad_alone: assert property (
        bad_frame |-> !cmd_valid && !txreq_valid ##1 !bad_frame)
        else $error("dropped frame still reported");
    a_boot_frame: assert property (
        $rose(nrst) |-> ##[1:3] tx_valid && tx_data == 8'h7E)
        else $error("no frame after reset release");
endmodule // rcsf_monitor

bind rcsf_top rcsf_monitor rcsf_monitor_inst (
    .clk(clk), .nrst(nrst), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .cmd_valid(cmd_valid),
    .cmd_frame_id(cmd_frame_id), .cmd_addr(cmd_addr),
    .cmd_broadcast(cmd_broadcast), .cmd_param_len(cmd_param_len),
    .cmd_query(cmd_query), .cmd_respond(cmd_respond),
    .txreq_valid(txreq_valid), .bad_frame(bad_frame)
);

// ==== rcsf_host_model.sv ====
`timescale 1ns/1ps
module rcsf_host_model (
    input  wire       clk,
    input  wire       rx_ready,
    output reg  [7:0] rx_data,
    output reg        rx_valid,
    input  wire [7:0] tx_data,
    input  wire       tx_valid,
    output reg        tx_ready
);
    logic [7:0] got_q [$];
    int         mode;
    int         cnt;

    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
        mode = 0;
        cnt = 0;
    end
    always @(posedge clk) begin
        if (tx_valid === 1'b1 && tx_ready) got_q.push_back(tx_data);
    end
    // Modes: 0 prompt, 1 stalls half the time, 2 halted to fill the buffer
    always @(negedge clk) begin
        cnt <= cnt + 1;
        tx_ready <= (mode == 0) || (mode == 1 && cnt[1]);
    end
    task automatic send(input logic [7:0] b [$], input bit bad);
        logic [7:0] f [$];
        logic [7:0] s;
        s = 8'h00;
        f = {8'h7E, 8'h00, 8'(b.size())};
        foreach (b[i]) s = s + b[i];
        f = {f, b, (8'hFF - s) ^ {7'h00, bad}};
        foreach (f[i]) begin
            @(negedge clk);
            rx_data = f[i];
            rx_valid = 1'b1;
            do @(posedge clk); while (rx_ready !== 1'b1);
        end
        @(negedge clk);
        rx_valid = 1'b0;
        // Released line shows the inverse so stale data never looks valid
        rx_data = ~rx_data;
    endtask
endmodule // rcsf_host_model

// ==== rcsf_top_tb.sv ====
`timescale 1ns/1ps
module rcsf_top_tb;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        evt_wdt_reset = 1'b0;
    logic        evt_net_wake = 1'b0;
    logic        evt_net_sleep = 1'b0;
    logic        tx_done = 1'b0;
    logic [7:0]  tx_done_retries = 8'h00;
    logic [7:0]  tx_done_delivery = 8'h00;
    logic        tx_done_discovery = 1'b0;
    wire  [7:0]  rx_data, tx_data, cmd_frame_id, cmd_param_len;
    wire  [7:0]  cmd_param_byte0, txreq_frame_id;
    wire  [63:0] cmd_addr;
    wire  [15:0] cmd_name;
    wire         rx_valid, rx_ready, tx_valid, tx_ready, cmd_valid;
    wire         cmd_broadcast, cmd_apply, cmd_query, cmd_respond;
    wire         txreq_valid, bad_frame, tx_busy;
    int          n_fail = 0;
    int          n_checks = 0;
    int          n_cmd = 0;
    int          n_txreq = 0;
    int          n_bad = 0;
    logic [7:0]  codes [8] = '{8'h00, 8'h01, 8'h02, 8'h21, 8'h25, 8'h31,
                               8'h32, 8'h74};

    always #4 clk = ~clk;

    rcsf_top rcsf_top_inst (
        .clk(clk), .nrst(nrst), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .evt_wdt_reset(evt_wdt_reset),
        .evt_net_wake(evt_net_wake), .evt_net_sleep(evt_net_sleep),
        .tx_done(tx_done), .tx_done_retries(tx_done_retries),
        .tx_done_delivery(tx_done_delivery),
        .tx_done_discovery(tx_done_discovery), .cmd_valid(cmd_valid),
        .cmd_frame_id(cmd_frame_id), .cmd_addr(cmd_addr),
        .cmd_broadcast(cmd_broadcast), .cmd_apply(cmd_apply),
        .cmd_name(cmd_name), .cmd_param_len(cmd_param_len),
        .cmd_param_byte0(cmd_param_byte0), .cmd_query(cmd_query),
        .cmd_respond(cmd_respond), .txreq_valid(txreq_valid),
        .txreq_frame_id(txreq_frame_id), .bad_frame(bad_frame),
        .tx_busy(tx_busy)
    );
    rcsf_host_model rcsf_host_model_inst (
        .clk(clk), .rx_ready(rx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready)
    );

    // Pulses are counted so a one-cycle flag is never missed
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
        if (txreq_valid === 1'b1) n_txreq <= n_txreq + 1;
        if (bad_frame === 1'b1) n_bad <= n_bad + 1;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wait_inc(ref int c, input int old);
        int k;
        k = 0;
        while (c == old && k < 300) begin
            @(negedge clk);
            k++;
        end
        chk(c != old, 1);
    endtask
    task automatic get_frame(input logic [7:0] b [$]);
        logic [7:0] s;
        int k;
        s = 8'h00;
        k = 0;
        foreach (b[i]) s = s + b[i];
        b = {8'h7E, 8'h00, 8'(b.size()), b, 8'hFF - s};
        while (rcsf_host_model_inst.got_q.size() < b.size() && k < 600) begin
            @(negedge clk);
            k++;
        end
        chk(rcsf_host_model_inst.got_q.size() >= b.size(), 1);
        foreach (b[i]) begin
            if (rcsf_host_model_inst.got_q.size() > 0)
                chk(rcsf_host_model_inst.got_q.pop_front(), b[i]);
        end
    endtask
    task automatic report_and_stop;
        if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic t_boot;
        get_frame({8'h8A, 8'h00});
        chk(rx_ready, 1);
    endtask
    task automatic t_events;
        rcsf_host_model_inst.mode = 2;
        @(negedge clk);
        {evt_wdt_reset, evt_net_wake, evt_net_sleep} = 3'h7;
        @(negedge clk);
        {evt_wdt_reset, evt_net_wake, evt_net_sleep} = 3'h0;
        // Three frames overfill the buffer
        repeat (40) @(negedge clk);
        chk(tx_busy, 1);
        rcsf_host_model_inst.mode = 1;
        get_frame({8'h8A, 8'h01});
        get_frame({8'h8A, 8'h0B});
        get_frame({8'h8A, 8'h0C});
    endtask
    task automatic t_cmd_set;
        logic [7:0] b [$];
        int old;
        old = n_cmd;
        b = {8'h17, 8'h01, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66,
             8'h77, 8'hFF, 8'hFE, 8'h02, 8'h42, 8'h48, 8'h01};
        rcsf_host_model_inst.send(b, 1'b0);
        wait_inc(n_cmd, old);
        chk(cmd_frame_id, 8'h01);
        chk(cmd_addr, 64'h0011223344556677);
        chk({cmd_broadcast, cmd_apply, cmd_query, cmd_respond}, 4'h5);
        chk(cmd_name, 16'h4248);
        chk({cmd_param_len, cmd_param_byte0}, 16'h0101);
    endtask
    task automatic t_cmd_query;
        logic [7:0] b [$];
        int old;
        old = n_cmd;
        b = {8'h17, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
             8'hFF, 8'hFF, 8'hFE, 8'h00, 8'h49, 8'h44};
        rcsf_host_model_inst.send(b, 1'b0);
        wait_inc(n_cmd, old);
        chk({cmd_broadcast, cmd_apply, cmd_query, cmd_respond}, 4'hA);
        chk(cmd_param_len, 8'h00);
    endtask
    task automatic t_bad;
        logic [7:0] b [$];
        int old;
        old = n_bad;
        b = {8'h17, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
             8'h01, 8'hFF, 8'hFE, 8'h00, 8'h42, 8'h48};
        rcsf_host_model_inst.send(b, 1'b1);
        wait_inc(n_bad, old);
        chk(n_cmd, 2);
        chk(cmd_frame_id, 8'h00);
    endtask
    task automatic t_result;
        logic [7:0] b [$];
        int old;
        for (int i = 0; i < 8; i++) begin
            old = n_txreq;
            b = {8'h10 + 8'(i % 2), 8'h40 + 8'(i), 8'h00, 8'h11, 8'h22,
                 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'hFF, 8'hFE, 8'h00,
                 8'h00, 8'h54};
            rcsf_host_model_inst.mode = i % 2;
            rcsf_host_model_inst.send(b, 1'b0);
            wait_inc(n_txreq, old);
            chk(txreq_frame_id, 8'h40 + 8'(i));
            @(negedge clk);
            tx_done = 1'b1;
            tx_done_retries = 8'(i);
            tx_done_delivery = codes[i];
            tx_done_discovery = i[1];
            @(negedge clk);
            tx_done = 1'b0;
            b = {8'h8B, 8'h40 + 8'(i), 8'hFF, 8'hFE, 8'(i), codes[i],
                 i[1] ? 8'h02 : 8'h00};
            get_frame(b);
        end
    endtask
    task automatic t_zero_id;
        logic [7:0] b [$];
        int old;
        old = n_txreq;
        b = {8'h11, 8'h00, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66,
             8'h77, 8'hFF, 8'hFE, 8'h00, 8'h00, 8'h54};
        rcsf_host_model_inst.send(b, 1'b0);
        wait_inc(n_txreq, old);
        @(negedge clk);
        tx_done = 1'b1;
        @(negedge clk);
        tx_done = 1'b0;
        repeat (40) @(negedge clk);
        chk(rcsf_host_model_inst.got_q.size(), 0);
        chk(tx_valid, 0);
    endtask

    initial begin
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        t_boot();
        t_events();
        t_cmd_set();
        t_cmd_query();
        t_bad();
        t_result();
        t_zero_id();
        report_and_stop();
    end
    // Run takes a few hundred cycles
    initial begin
        #200000;
        n_fail++;
        report_and_stop();
    end
endmodule // rcsf_top_tb
